// >>> logic/hpdi_port.sv
/*
 Downstream hub port logic: test state, full-/low-speed disconnect timer,
 K/SE0 noise filter and two-colour port indicator, with an AHB-Lite
 register slave and one interrupt. Assumes the port state machine and hub
 controller run on I_SYS_CLK; D+ and D- arrive asynchronously.
*/
// Design decisions made here: the AHB-Lite register port and the register addresses.
// What this block does
// - Test command enters Testing from anywhere
// - Forced-enable test gives Enabled-style downstream connectivity
// - Per-port disconnect timer watches single-ended receivers
// - Timer reset outside SE0/SE1 or allowed states
// - Timer held 4 ms entering Suspended/Disabled
// - Debounce interval of 2.0 to 2.5 us
// - Expiry raises disconnect detect to port machine
// - Timer also filters K/SE0 in suspend/restart
// - Traits bit 7 reports indicator presence
// - Indicator shows green, amber or off
// - Automatic colour; selector zero on configuration
// - Indicators off when hub suspended/unconfigured
// - Automatic mapping with power switching
// - Automatic mapping without power switching
// - Manual selection displayed; automatic from port state
// - Blink patterns carry attention meanings
// - Forced software state honoured for any colour
`timescale 1ns/1ps
module hpdi_port #(
   parameter int unsigned HOLD_CYCLES     = hpdi_pkg::HOLD_CYCLES,
   parameter int unsigned BLINK_CYCLES    = hpdi_pkg::BLINK_CYCLES,
   parameter bit          POWER_SWITCHING = 1'b1,
   parameter bit          HAS_INDICATORS  = 1'b1
) (
   // Clock and reset
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_SRST,
   // AHB-Lite slave
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic [31:0]      O_HRDATA,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   // Port state machine and hub controller
   input  wire logic [3:0]  I_PORT_STATE,
   input  wire logic        I_TEST_CMD,
   input  wire logic [2:0]  I_TEST_SEL,
   input  wire logic        I_LOW_SPEED,
   input  wire logic        I_HUB_CONFIGURED,
   input  wire logic        I_HUB_SUSPENDED,
   input  wire logic        I_OVER_CURRENT,
   output logic             O_PORT_TESTING,
   output logic             O_DS_CONNECT,
   output logic             O_DISC_DETECT,
   output logic             O_PERSIST_K,
   output logic             O_PERSIST_SE0,
   output logic [15:0]      O_HUB_TRAITS,
   // Line receivers
   input  wire logic        I_DP,
   input  wire logic        I_DM,
   // Indicator LEDs
   output logic             O_LED_GREEN,
   output logic             O_LED_AMBER,
   // Interrupt
   output logic             O_IRQ
);

   localparam int unsigned HOLD_W  = $clog2(HOLD_CYCLES + 1);
   localparam int unsigned BLINK_W = $clog2(BLINK_CYCLES);
   localparam logic [HOLD_W-1:0]  HOLD_LOAD = HOLD_W'(HOLD_CYCLES);
   localparam logic [BLINK_W-1:0] BLINK_TOP = BLINK_W'(BLINK_CYCLES - 1);

   typedef enum logic {
      TS_NORMAL  = 1'b0,
      TS_TESTING = 1'b1
   } hpdi_test_e;

   logic                          dp_s1_q, dp_s2_q, dm_s1_q, dm_s2_q;
   logic                          se0, se1, k_line;
   hpdi_test_e                    test_q;
   logic [hpdi_pkg::TSEL_W-1:0]   test_sel_q;
   hpdi_pkg::hpdi_port_state_e    eff_state, prev_state_q;
   logic                          disc_win, filt_win, hold_entry;
   logic [HOLD_W-1:0]             hold_q;
   logic                          disc_clear, disc_exp, filt_exp;
   logic                          disc_prev_q, filt_prev_q, oc_prev_q, cfg_prev_q;
   logic [BLINK_W-1:0]            blink_cnt_q;
   logic                          blink_ph_q;
   logic [hpdi_pkg::SEL_W-1:0]    sel_q;
   logic                          auto_g, auto_a, led_g_d, led_a_d;
   logic                          led_g_q, led_a_q;
   logic [15:0]                   traits_q;
   logic [hpdi_pkg::IRQ_W-1:0]    irq_stat_q, irq_mask_q, irq_ev;
   logic                          dp_valid_q, dp_write_q, rd_pend_q;
   logic [hpdi_pkg::ADDR_W-1:0]   dp_addr_q;
   logic [31:0]                   rdata, status, hrdata_q;
   logic                          wr_en;

   // Line receivers come from the pins
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         dp_s1_q <= 1'b0;
         dp_s2_q <= 1'b0;
         dm_s1_q <= 1'b0;
         dm_s2_q <= 1'b0;
      end else begin
         dp_s1_q <= I_DP;
         dp_s2_q <= dp_s1_q;
         dm_s1_q <= I_DM;
         dm_s2_q <= dm_s1_q;
      end
   end

   assign se0    = !dp_s2_q && !dm_s2_q;
   assign se1    = dp_s2_q && dm_s2_q;
   // Low speed swaps the J and K polarity
   assign k_line = I_LOW_SPEED ? (dp_s2_q && !dm_s2_q) : (!dp_s2_q && dm_s2_q);

   // Testing is left only through hub reset
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         test_q     <= TS_NORMAL;
         test_sel_q <= '0;
      end else begin
         case (test_q)
            TS_NORMAL: begin
               if (I_TEST_CMD) begin
                  test_q     <= TS_TESTING;
                  test_sel_q <= I_TEST_SEL;
               end
            end
            TS_TESTING: begin
               if (I_TEST_CMD) begin
                  test_sel_q <= I_TEST_SEL;
               end
            end
            default: test_q <= TS_NORMAL;
         endcase
      end
   end

   assign eff_state = (test_q == TS_TESTING) ? hpdi_pkg::PS_TESTING
                                             : hpdi_pkg::hpdi_port_state_e'(I_PORT_STATE);
   assign O_PORT_TESTING = (test_q == TS_TESTING);
   assign O_DS_CONNECT   = (eff_state == hpdi_pkg::PS_ENABLED) ||
                           ((test_q == TS_TESTING) &&
                            (test_sel_q == hpdi_pkg::TSEL_FORCE_ENABLE));

   // Disconnect timer window and post-entry hold
   assign disc_win = (eff_state == hpdi_pkg::PS_ENABLED)   ||
                     (eff_state == hpdi_pkg::PS_SUSPENDED) ||
                     (eff_state == hpdi_pkg::PS_DISABLED)  ||
                     (eff_state == hpdi_pkg::PS_RESTART_E) ||
                     (eff_state == hpdi_pkg::PS_RESTART_S);
   assign filt_win = (eff_state == hpdi_pkg::PS_SUSPENDED) ||
                     (eff_state == hpdi_pkg::PS_RESTART_E) ||
                     (eff_state == hpdi_pkg::PS_RESTART_S);
   assign hold_entry = (eff_state != prev_state_q) &&
                       ((eff_state == hpdi_pkg::PS_SUSPENDED) ||
                        (eff_state == hpdi_pkg::PS_DISABLED));

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         prev_state_q <= hpdi_pkg::PS_POWERED_OFF;
      end else begin
         prev_state_q <= eff_state;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         hold_q <= '0;
      end else if (hold_entry) begin
         hold_q <= HOLD_LOAD;
      end else if (hold_q != '0) begin
         hold_q <= hold_q - 1'b1;
      end
   end

   assign disc_clear = !disc_win || hold_entry || (hold_q != '0);

   hpdi_debounce #(
      .LIMIT     (hpdi_pkg::DDIS_CYCLES)
   ) u_disc_timer (
      .i_clk     (I_SYS_CLK),
      .i_srst    (I_SRST),
      .i_clear   (disc_clear),
      .i_level   (se0 || se1),
      .o_expired (disc_exp)
   );

   // Same timer design reused as the K/SE0 noise filter
   hpdi_debounce #(
      .LIMIT     (hpdi_pkg::DDIS_CYCLES)
   ) u_kse0_filter (
      .i_clk     (I_SYS_CLK),
      .i_srst    (I_SRST),
      .i_clear   (!filt_win),
      .i_level   (k_line || se0),
      .o_expired (filt_exp)
   );

   assign O_DISC_DETECT = disc_exp;
   assign O_PERSIST_K   = filt_exp && k_line;
   assign O_PERSIST_SE0 = filt_exp && se0;

   // Blink divider; rate is a parameter only
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         blink_cnt_q <= '0;
         blink_ph_q  <= 1'b0;
      end else if (blink_cnt_q == BLINK_TOP) begin
         blink_cnt_q <= '0;
         blink_ph_q  <= !blink_ph_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 1'b1;
      end
   end

   // Automatic colour from port state
   always_comb begin
      auto_g = 1'b0;
      auto_a = 1'b0;
      case (eff_state)
         hpdi_pkg::PS_POWERED_OFF: begin
            auto_a = POWER_SWITCHING && I_OVER_CURRENT;
         end
         hpdi_pkg::PS_DISCONNECTED, hpdi_pkg::PS_DISABLED, hpdi_pkg::PS_NOT_CONFIGURED,
         hpdi_pkg::PS_RESETTING, hpdi_pkg::PS_TESTING: begin
            auto_a = !POWER_SWITCHING && I_OVER_CURRENT;
         end
         hpdi_pkg::PS_ENABLED, hpdi_pkg::PS_TRANSMIT, hpdi_pkg::PS_TRANSMIT_RESUME: begin
            auto_g = 1'b1;
         end
         default: begin
            auto_g = 1'b0;
         end
      endcase
   end

   // Manual selection overrides; blinking works for any colour pair
   always_comb begin
      led_g_d = 1'b0;
      led_a_d = 1'b0;
      case (hpdi_pkg::hpdi_ind_sel_e'(sel_q))
         hpdi_pkg::IND_AUTO: begin
            led_g_d = auto_g;
            led_a_d = auto_a;
         end
         hpdi_pkg::IND_AMBER:    led_a_d = 1'b1;
         hpdi_pkg::IND_GREEN:    led_g_d = 1'b1;
         hpdi_pkg::IND_BLINK_OG: led_g_d = blink_ph_q;
         hpdi_pkg::IND_BLINK_OA: led_a_d = blink_ph_q;
         hpdi_pkg::IND_BLINK_GA: begin
            led_g_d = blink_ph_q;
            led_a_d = !blink_ph_q;
         end
         default: begin
            led_g_d = 1'b0;
         end
      endcase
      if (!HAS_INDICATORS || I_HUB_SUSPENDED || !I_HUB_CONFIGURED) begin
         led_g_d = 1'b0;
         led_a_d = 1'b0;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         led_g_q <= 1'b0;
         led_a_q <= 1'b0;
      end else begin
         led_g_q <= led_g_d;
         led_a_q <= led_a_d;
      end
   end

   assign O_LED_GREEN = led_g_q;
   assign O_LED_AMBER = led_a_q;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         traits_q <= '0;
      end else begin
         traits_q                           <= '0;
         traits_q[hpdi_pkg::TRAITS_IND_BIT] <= HAS_INDICATORS;
      end
   end

   assign O_HUB_TRAITS = traits_q;

   // Event edges
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         disc_prev_q <= 1'b0;
         filt_prev_q <= 1'b0;
         oc_prev_q   <= 1'b0;
         cfg_prev_q  <= 1'b0;
      end else begin
         disc_prev_q <= disc_exp;
         filt_prev_q <= filt_exp;
         oc_prev_q   <= I_OVER_CURRENT;
         cfg_prev_q  <= I_HUB_CONFIGURED;
      end
   end

   always_comb begin
      irq_ev                        = '0;
      irq_ev[hpdi_pkg::IRQ_DISC]    = disc_exp && !disc_prev_q;
      irq_ev[hpdi_pkg::IRQ_PERSIST] = filt_exp && !filt_prev_q;
      irq_ev[hpdi_pkg::IRQ_TEST]    = I_TEST_CMD && (test_q == TS_NORMAL);
      irq_ev[hpdi_pkg::IRQ_OC]      = I_OVER_CURRENT && !oc_prev_q;
   end

   // AHB-Lite slave: writes zero-wait, reads one wait state
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         dp_valid_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_addr_q  <= '0;
      end else if (I_HREADY) begin
         dp_valid_q <= I_HSEL && I_HTRANS[hpdi_pkg::HTRANS_ACT_BIT];
         dp_write_q <= I_HWRITE;
         dp_addr_q  <= I_HADDR[hpdi_pkg::ADDR_W-1:0];
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         rd_pend_q <= 1'b0;
      end else begin
         rd_pend_q <= I_HREADY && I_HSEL && I_HTRANS[hpdi_pkg::HTRANS_ACT_BIT] && !I_HWRITE;
      end
   end

   assign wr_en = dp_valid_q && dp_write_q;

   always_comb begin
      status                                     = '0;
      status[hpdi_pkg::ST_DISC]                  = disc_exp;
      status[hpdi_pkg::ST_PERSIST]               = filt_exp;
      status[hpdi_pkg::ST_TESTING]               = (test_q == TS_TESTING);
      status[hpdi_pkg::ST_SE0]                   = se0;
      status[hpdi_pkg::ST_SE1]                   = se1;
      status[hpdi_pkg::ST_K]                     = k_line;
      status[hpdi_pkg::ST_GREEN]                 = led_g_q;
      status[hpdi_pkg::ST_AMBER]                 = led_a_q;
      status[hpdi_pkg::ST_TSEL_LSB +: hpdi_pkg::TSEL_W] = test_sel_q;
      status[hpdi_pkg::ST_STATE_LSB +: 4]        = eff_state;
   end

   always_comb begin
      rdata = '0;
      if (dp_addr_q == hpdi_pkg::REG_CTRL) begin
         rdata[hpdi_pkg::SEL_W-1:0] = sel_q;
      end else if (dp_addr_q == hpdi_pkg::REG_STATUS) begin
         rdata = status;
      end else if (dp_addr_q == hpdi_pkg::REG_IRQ_STAT) begin
         rdata[hpdi_pkg::IRQ_W-1:0] = irq_stat_q;
      end else if (dp_addr_q == hpdi_pkg::REG_IRQ_MASK) begin
         rdata[hpdi_pkg::IRQ_W-1:0] = irq_mask_q;
      end else if (dp_addr_q == hpdi_pkg::REG_TRAITS) begin
         rdata[15:0] = traits_q;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         hrdata_q <= '0;
      end else if (rd_pend_q) begin
         hrdata_q <= rdata;
      end
   end

   assign O_HRDATA    = hrdata_q;
   assign O_HREADYOUT = !rd_pend_q;
   assign O_HRESP     = 1'b0;

   // Configuration forces automatic mode over a same-cycle write
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         sel_q <= hpdi_pkg::IND_AUTO;
      end else if (I_HUB_CONFIGURED && !cfg_prev_q) begin
         sel_q <= hpdi_pkg::IND_AUTO;
      end else if (wr_en && (dp_addr_q == hpdi_pkg::REG_CTRL)) begin
         sel_q <= I_HWDATA[hpdi_pkg::SEL_W-1:0];
      end
   end

   // Set wins over write-one-to-clear
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         irq_stat_q <= '0;
      end else if (wr_en && (dp_addr_q == hpdi_pkg::REG_IRQ_STAT)) begin
         irq_stat_q <= (irq_stat_q & ~I_HWDATA[hpdi_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_stat_q <= irq_stat_q | irq_ev;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         irq_mask_q <= '0;
      end else if (wr_en && (dp_addr_q == hpdi_pkg::REG_IRQ_MASK)) begin
         irq_mask_q <= I_HWDATA[hpdi_pkg::IRQ_W-1:0];
      end
   end

   assign O_IRQ = |(irq_stat_q & irq_mask_q);

   // Checks
   sequence line_bad_s;
      !(se0 || se1);
   endsequence

   sequence entry_s;
      hold_entry;
   endsequence

   test_entry_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      I_TEST_CMD |=> O_PORT_TESTING && (eff_state == hpdi_pkg::PS_TESTING))
      else $error("test command did not enter Testing");

   force_enable_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (I_TEST_CMD && (I_TEST_SEL == hpdi_pkg::TSEL_FORCE_ENABLE)) |=> O_DS_CONNECT)
      else $error("forced enable lacks downstream connectivity");

   timer_idle_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      line_bad_s |=> !O_DISC_DETECT)
      else $error("disconnect seen without SE0 or SE1");

   hold_block_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      entry_s |=> (!O_DISC_DETECT && (hold_q != '0)) [*8])
      else $error("disconnect timer not held after entry");

   disc_latency_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      $rose(O_DISC_DETECT) |-> ($past(se0) || $past(se1)) && !$past(disc_clear))
      else $error("disconnect raised without running timer");

   win_block_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      !disc_win |=> !O_DISC_DETECT)
      else $error("disconnect outside allowed port states");

   leds_off_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (I_HUB_SUSPENDED || !I_HUB_CONFIGURED) |=> !O_LED_GREEN && !O_LED_AMBER)
      else $error("indicator lit while hub idle");

   auto_green_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (HAS_INDICATORS && (sel_q == hpdi_pkg::IND_AUTO) && I_HUB_CONFIGURED &&
       !I_HUB_SUSPENDED && (eff_state == hpdi_pkg::PS_ENABLED))
      |=> O_LED_GREEN && !O_LED_AMBER)
      else $error("enabled port not green");

   cfg_auto_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      (I_HUB_CONFIGURED && !cfg_prev_q) |=> (sel_q == hpdi_pkg::IND_AUTO))
      else $error("selector not automatic on configuration");

   irq_sticky_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
      irq_ev[hpdi_pkg::IRQ_DISC] |=> irq_stat_q[hpdi_pkg::IRQ_DISC])
      else $error("disconnect event lost");

endmodule

// >>> shared/hpdi_pkg.sv
/*
 Shared constants and types for the hub port disconnect and indicator block:
 port state codes, indicator selector codes, timing figures, register map.
 Assumes a single 100 MHz hub clock.
*/
package hpdi_pkg;

   // Clock and timing figures
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned DDIS_MIN_NS    = 2000;
   localparam int unsigned DDIS_MAX_NS    = 2500;
   localparam int unsigned DDIS_CYCLES    = (DDIS_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned HOLD_MS        = 4;
   localparam int unsigned HOLD_CYCLES    = HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned BLINK_HALF_MS  = 500;
   localparam int unsigned BLINK_CYCLES   = BLINK_HALF_MS * (CLK_HZ / 1000);

   // Port state as reported by the port state machine
   typedef enum logic [3:0] {
      PS_POWERED_OFF            = 4'h0,
      PS_DISCONNECTED           = 4'h1,
      PS_DISABLED               = 4'h2,
      PS_RESETTING              = 4'h3,
      PS_ENABLED                = 4'h4,
      PS_TRANSMIT               = 4'h5,
      PS_TRANSMIT_RESUME        = 4'h6,
      PS_SUSPENDED              = 4'h7,
      PS_RESUMING               = 4'h8,
      PS_SEND_END_OF_RESUME     = 4'h9,
      PS_RESTART_S              = 4'hA,
      PS_RESTART_E              = 4'hB,
      PS_TESTING                = 4'hC,
      PS_NOT_CONFIGURED         = 4'hD
   } hpdi_port_state_e;

   // Indicator colour selector
   localparam int unsigned SEL_W = 3;
   typedef enum logic [SEL_W-1:0] {
      IND_AUTO        = 3'h0,
      IND_AMBER       = 3'h1,
      IND_GREEN       = 3'h2,
      IND_OFF         = 3'h3,
      IND_BLINK_OG    = 3'h4,
      IND_BLINK_OA    = 3'h5,
      IND_BLINK_GA    = 3'h6
   } hpdi_ind_sel_e;

   // Test selectors
   localparam int unsigned TSEL_W                = 3;
   localparam logic [TSEL_W-1:0] TSEL_FORCE_ENABLE = 3'h5;

   // Hub traits field
   localparam int unsigned TRAITS_W       = 16;
   localparam int unsigned TRAITS_IND_BIT = 7;

   // Register map, byte addresses
   localparam int unsigned ADDR_W                = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL        = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS      = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT    = 8'h08;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK    = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_TRAITS      = 8'h10;

   // Status field positions
   localparam int unsigned ST_DISC      = 0;
   localparam int unsigned ST_PERSIST   = 1;
   localparam int unsigned ST_TESTING   = 2;
   localparam int unsigned ST_SE0       = 3;
   localparam int unsigned ST_SE1       = 4;
   localparam int unsigned ST_K         = 5;
   localparam int unsigned ST_GREEN     = 6;
   localparam int unsigned ST_AMBER     = 7;
   localparam int unsigned ST_TSEL_LSB  = 8;
   localparam int unsigned ST_STATE_LSB = 12;

   // Interrupt bits
   localparam int unsigned IRQ_W       = 4;
   localparam int unsigned IRQ_DISC    = 0;
   localparam int unsigned IRQ_PERSIST = 1;
   localparam int unsigned IRQ_TEST    = 2;
   localparam int unsigned IRQ_OC      = 3;

   localparam int unsigned HTRANS_ACT_BIT = 1;

endpackage

// >>> logic/hpdi_debounce.sv
/*
 Saturating line-condition timer: counts cycles of a continuous level and
 flags expiry once LIMIT cycles have been seen.
 Assumes i_level is already synchronised to i_clk.
*/
`timescale 1ns/1ps
module hpdi_debounce #(
   parameter int unsigned LIMIT = 200
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_srst,
   // Control
   input  wire logic i_clear,
   input  wire logic i_level,
   // Result
   output logic      o_expired
);

   localparam int unsigned CNT_W = $clog2(LIMIT + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(LIMIT);

   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge i_clk) begin
      if (i_srst || i_clear || !i_level) begin
         cnt_q <= '0;
      end else if (cnt_q != CNT_MAX) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign o_expired = (cnt_q == CNT_MAX);

endmodule

// >>> test/hpdi_dev_model.sv
/*
 Attached full-/low-speed device model driving D+ and D- of the port.
 Assumes line codes 0 J, 1 K, 2 SE0, 3 SE1 chosen by the bench.
*/
`timescale 1ns/1ps
module hpdi_dev_model (
   // Line request
   input  wire logic       i_low_speed,
   input  wire logic [1:0] i_line,
   // Bus pins
   output logic            o_dp,
   output logic            o_dm
);
   // Low speed idles with D- high, so J and K swap
   always_comb begin
      o_dp = (i_line == 2'h3) | (((i_line == 2'h0) ^ i_low_speed) & (i_line < 2'h2));
      o_dm = (i_line == 2'h3) | (((i_line == 2'h1) ^ i_low_speed) & (i_line < 2'h2));
   end
endmodule

// >>> test/hpdi_port_tb_top.sv
/*
 Self-checking bench for hpdi_port: bus tasks, line model, timer and indicators.
 Assumes short hold and blink parameters and a 100 MHz clock.
*/
`timescale 1ns/1ps
module hpdi_port_tb_top;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rd;
   logic [3:0]  pst = 4'h4;
   logic [2:0]  tsel = 3'h0;
   logic [1:0]  line = 2'h0;
   logic        tcmd = 1'b0, ls = 1'b0, cfg = 1'b1, susp = 1'b0, oc = 1'b0;
   logic        hrdy, tst, dsc, disc, pk, dp, dm, g, a, irq, hresp, ps0;
   logic [15:0] trt;
   logic [31:0] seed = 32'h1e85_f36c;
   int          err_total = 0;
   int          samples_checked = 0;
   int          gn, an;
   // Short blink half period keeps the run brief
   localparam int BLK = 8;

   always #5 clk = ~clk;

   hpdi_port #(.HOLD_CYCLES(50), .BLINK_CYCLES(BLK)) DUT (
      .I_SYS_CLK(clk), .I_SRST(srst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy),
      .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_PORT_STATE(pst),
      .I_TEST_CMD(tcmd), .I_TEST_SEL(tsel), .I_LOW_SPEED(ls), .I_HUB_CONFIGURED(cfg),
      .I_HUB_SUSPENDED(susp), .I_OVER_CURRENT(oc), .O_PORT_TESTING(tst), .O_DS_CONNECT(dsc),
      .O_DISC_DETECT(disc), .O_PERSIST_K(pk), .O_PERSIST_SE0(ps0), .O_HUB_TRAITS(trt),
      .I_DP(dp), .I_DM(dm), .O_LED_GREEN(g), .O_LED_AMBER(a), .O_IRQ(irq));

   hpdi_dev_model DEV (.i_low_speed(ls), .i_line(line), .o_dp(dp), .o_dm(dm));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Expected {green, amber} in automatic mode with power switching
   function automatic logic [31:0] auto_led(input logic [3:0] s, input logic o);
      if (s == hpdi_pkg::PS_ENABLED || s == hpdi_pkg::PS_TRANSMIT ||
          s == hpdi_pkg::PS_TRANSMIT_RESUME) return 32'h0000_0002;
      return {31'h0, s == hpdi_pkg::PS_POWERED_OFF && o};
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t %s", $time, m);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, ad};
      hwrite <= wr;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (hrdy !== 1'b1 && n < 40);
         chk(32'(n < 40), 32'h0000_0001, "bus hang");
         if (n >= 40) tally_and_finish();
         if (p == 0) begin
            // Select stays up so back-to-back calls never reassign it in one step
            htrans <= 2'h0;
            hwdata <= wd;
         end
      end
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0000_0000, "bus response");
   endtask

   // Waits for disconnect (k=0) or persistent K (k=1) inside a window
   task automatic wait_hi(input bit k, input int lo, input int hi);
      int n;
      n = 0;
      while ((k ? pk : disc) !== 1'b1 && n < hi) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n >= lo && n < hi), 32'h0000_0001, "timer window");
      if (n >= hi) tally_and_finish();
   endtask

   task automatic do_reset;
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse_test(input logic [2:0] s);
      tcmd <= 1'b1;
      tsel <= s;
      @(posedge clk);
      tcmd <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   initial begin
      do_reset();
      bus(1'b0, hpdi_pkg::REG_TRAITS, 32'h0000_0000);
      chk(rd, 32'h0000_0080, "traits");
      chk({16'h0000, trt}, 32'h0000_0080, "traits port");
      bus(1'b0, 8'h20, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped");
      seed = lfsr(seed);
      ls <= seed[1];
      line <= seed[0] ? 2'h3 : 2'h2;
      wait_hi(1'b0, 200, 260);
      chk({31'h0, irq}, 32'h0000_0000, "masked irq");
      bus(1'b1, hpdi_pkg::REG_IRQ_MASK, 32'h0000_0001);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0001, "irq on");
      bus(1'b1, hpdi_pkg::REG_IRQ_STAT, 32'h0000_0001);
      line <= 2'h0;
      repeat (5) @(posedge clk);
      chk({30'h0, disc, irq}, 32'h0000_0000, "line idle");
      pst <= hpdi_pkg::PS_RESETTING;
      line <= 2'h2;
      repeat (300) @(posedge clk);
      chk({31'h0, disc}, 32'h0000_0000, "state outside");
      pst <= hpdi_pkg::PS_SUSPENDED;
      wait_hi(1'b0, 250, 320);
      chk({30'h0, pk, ps0}, 32'h0000_0001, "persist se0");
      // Idle gap so the filter restarts; SE0 straight into K would not
      line <= 2'h0;
      repeat (5) @(posedge clk);
      line <= 2'h1;
      wait_hi(1'b1, 200, 260);
      line <= 2'h0;
      for (int s = 0; s < 14; s++) begin
         seed = lfsr(seed);
         pst <= 4'(s);
         oc <= seed[0];
         repeat (3) @(posedge clk);
         chk({30'h0, g, a}, auto_led(4'(s), seed[0]), "auto led");
      end
      for (int c = 1; c < 4; c++) begin
         bus(1'b1, hpdi_pkg::REG_CTRL, 32'(c));
         repeat (2) @(posedge clk);
         chk({30'h0, g, a}, c == 2 ? 32'h2 : 32'(c == 1), "manual");
      end
      for (int c = 4; c < 7; c++) begin
         bus(1'b1, hpdi_pkg::REG_CTRL, 32'(c));
         gn = 0;
         an = 0;
         // First edge still shows the old selector; then whole blink periods
         @(posedge clk);
         repeat (4 * BLK) begin
            @(posedge clk);
            gn += int'(g);
            an += int'(a);
         end
         chk(32'(gn), c == 5 ? 32'h0000_0000 : 32'(2 * BLK), "blink green");
         chk(32'(an), c == 4 ? 32'h0000_0000 : 32'(2 * BLK), "blink amber");
      end
      susp <= 1'b1;
      repeat (3) @(posedge clk);
      chk({30'h0, g, a}, 32'h0000_0000, "suspended off");
      susp <= 1'b0;
      cfg <= 1'b0;
      repeat (3) @(posedge clk);
      chk({30'h0, g, a}, 32'h0000_0000, "unconfigured off");
      cfg <= 1'b1;
      @(posedge clk);
      bus(1'b0, hpdi_pkg::REG_CTRL, 32'h0000_0000);
      chk({29'h0, rd[2:0]}, 32'h0000_0000, "auto on config");
      pulse_test(3'h3);
      chk({30'h0, tst, dsc}, 32'h0000_0002, "testing");
      do_reset();
      pulse_test(hpdi_pkg::TSEL_FORCE_ENABLE);
      chk({30'h0, tst, dsc}, 32'h0000_0003, "force enable");
      tally_and_finish();
   end
endmodule
